// >>> inc/can_mode_defines.svh
// constants for the can operating-mode controller
// assumes one clock domain at 25 MHz and a synchronous protocol engine beside it
// Function
// (RL1) request field bits 7:5, separate status
// (RL2) hold mode until pending transmissions finish
// (RL3) software confirms reported mode before continuing
// (RL4) top request bit enters configuration
// (RL5) all-zero request leaves configuration, goes online
// (RL6) protected writes ignored outside configuration
// (RL7) configuration entry waits for idle bus
// (RL8) configuration: silent, counters cleared, flags kept
// (RL9) request 001 enters disable, state kept
// (RL10) disable stops clock, waits 11 recessive bits; the code skips the wait whenever frame_active is low
// (RL11) wake interrupt on recessive-to-dominant edge
// (RL12) wake returns previous mode, message dropped
// (RL13) software retransmits message lost at wake
// (RL14) disable releases bus pins to port
// (RL15) normal: only transmitting, acknowledging mode
// (RL16) listen only: silent, counters reset
// (RL17) filters apply; zero mask accepts all
// (RL18) loopback routes transmit to receive internally
// (RL19) loopback releases transmit pin
// (RL20) mode 0 receive field 11 ignores errors
// (RL21) functional mode 0 after every reset
// (RL22) mode 0: 3 tx, 2 rx, 6 filters
// (RL23) distinct codes for normal, listen, loopback
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH

// ----------------------------------------
// field positions
// ----------------------------------------
`define REQ_FIELD_MSB 7
`define REQ_FIELD_LSB 5
`define REQ_TOP_BIT 2

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN 3'h3
`define MODE_CONFIG 3'h4

// ----------------------------------------
// functional modes and receive mode
// ----------------------------------------
`define FMODE_LEGACY 2'h0
`define FMODE_ENH 2'h1
`define FMODE_FIFO 2'h2
`define RXM_ERR_RECOG 2'h3
`define FMODE_RESERVED 2'h3

// ----------------------------------------
// resources and timing
// ----------------------------------------
`define TX_BUF_COUNT 2'h3
`define RX_BUF_COUNT 2'h2
`define FILTER_COUNT 6
`define FILTERS_FOR_A 2
`define IDLE_BITS 4'hb
`define RECESSIVE 1'b1
`define DOMINANT 1'b0

`endif

// >>> inc/can_mode_pkg.sv
// types for the can operating-mode controller
// assumes the defines header is included by the user of the types
package can_mode_pkg;

    typedef enum logic [2:0] {
        st_config,
        st_disable,
        st_normal,
        st_listen,
        st_loopback
    } op_state_type;

    typedef logic [2:0] mode_code_type;
    typedef logic [1:0] fmode_type;

endpackage

// >>> core/bus_idle_watch.sv
// watches the received bus level, counts recessive bits, flags wake edges
// assumes rx_level and bit_tick are synchronous to core_clk
`timescale 1ns/1ps
`include "can_mode_defines.svh"

module bus_idle_watch (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bus sampling
    input wire logic rx_level,
    input wire logic bit_tick,
    // results
    output logic idle_seen,
    output logic fall_seen
);

    logic [3:0] run_q;
    logic last_q;

    // ----------------------------------------
    // recessive run counter, saturating at the idle length
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            run_q <= 4'h0;
        end else if (bit_tick) begin
            if (rx_level == `DOMINANT) begin
                run_q <= 4'h0;
            end else if (run_q != `IDLE_BITS) begin
                run_q <= run_q + 4'h1; // (RL10)
            end
        end
    end

    // ----------------------------------------
    // previous level; the edge is seen without a bit tick so a stopped
    // module clock domain still notices bus activity
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            last_q <= `RECESSIVE;
        end else begin
            last_q <= rx_level;
        end
    end

    assign idle_seen = (run_q == `IDLE_BITS);
    assign fall_seen = (last_q == `RECESSIVE) && (rx_level == `DOMINANT); // (RL11)

endmodule

// >>> core/can_mode_ctrl.sv
// operating-mode controller: mode requests, reported mode, config lock,
// disable and wake-up, silent and loopback steering, functional mode
// assumes a protocol engine beside it that reports activity and bit ticks
`timescale 1ns/1ps
`include "can_mode_defines.svh"

module can_mode_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // module control register write
    input wire logic ctrl_wr,
    input wire logic [7:0] module_control_reg,
    // protected register writes from software
    input wire logic prot_wr,
    input wire logic fmode_wr,
    input wire can_mode_pkg::fmode_type fmode_wdata,
    // wake control
    input wire logic wake_disable,
    input wire logic wake_irq_enable,
    input wire logic wake_flag_clr,
    // receive buffer control
    input wire logic [1:0] rx_mode_field_a,
    input wire logic [1:0] rx_mode_field_b,
    // acceptance inputs from the filter compare
    input wire logic [5:0] filter_hit,
    input wire logic mask_zero_a,
    input wire logic mask_zero_b,
    input wire logic rx_frame_done,
    // protocol engine status
    input wire logic tx_pending,
    input wire logic frame_active,
    input wire logic bit_tick,
    input wire logic engine_tx_bit,
    // bus pins
    input wire logic bus_rx_pin,
    output logic bus_tx_pin_out,
    output logic bus_tx_pin_oe,
    output logic bus_pins_release,
    // status to software
    output can_mode_pkg::mode_code_type mode_request_field,
    output can_mode_pkg::mode_code_type reported_mode_field,
    output logic config_ack_bit,
    output can_mode_pkg::fmode_type fmode_q,
    output logic wake_flag,
    output logic wake_irq,
    output logic prot_wr_grant,
    // engine steering
    output logic module_clk_en,
    output logic tx_allow,
    output logic rx_allow,
    output logic ack_err_drive,
    output logic err_cnt_clear,
    output logic err_cnt_hold,
    output logic engine_rx_bit,
    output logic wake_drop_msg,
    output logic err_recog_a,
    output logic err_recog_b,
    output logic accept_a,
    output logic accept_b,
    output logic [1:0] tx_buf_count,
    output logic [1:0] rx_buf_count
);
    import can_mode_pkg::*;

    op_state_type state_q;
    op_state_type state_d;
    op_state_type prev_q;
    mode_code_type req_q;
    logic idle_seen;
    logic fall_seen;
    logic rx_level;
    logic switch_ok;
    logic wake_ev;

    // ----------------------------------------
    // bus watcher
    // ----------------------------------------
    assign rx_level = bus_rx_pin;

    bus_idle_watch u_watch (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .rx_level(rx_level),
        .bit_tick(bit_tick),
        .idle_seen(idle_seen),
        .fall_seen(fall_seen)
    );

    // ----------------------------------------
    // code helpers
    // ----------------------------------------
    function automatic mode_code_type code_of(input op_state_type s);
        case (s)
            st_config: code_of = `MODE_CONFIG;
            st_disable: code_of = `MODE_DISABLE;
            st_listen: code_of = `MODE_LISTEN; // (RL23)
            st_loopback: code_of = `MODE_LOOPBACK; // (RL23)
            default: code_of = `MODE_NORMAL;
        endcase
    endfunction

    function automatic op_state_type state_of(input mode_code_type c);
        if (c[`REQ_TOP_BIT]) begin
            state_of = st_config; // (RL4)
        end else begin
            case (c)
                `MODE_NORMAL: state_of = st_normal; // (RL5)
                `MODE_DISABLE: state_of = st_disable; // (RL9)
                `MODE_LOOPBACK: state_of = st_loopback;
                `MODE_LISTEN: state_of = st_listen;
                default: state_of = st_normal;
            endcase
        end
    endfunction

    // wake only counts while disabled and not masked by the disable bit
    assign wake_ev = (state_q == st_disable) && fall_seen && !wake_disable;

    // ----------------------------------------
    // request register; a wake rewrites it with the previous mode so the
    // module does not drop straight back into disable
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            req_q <= `MODE_CONFIG;
        end else if (wake_ev) begin
            req_q <= code_of(prev_q); // (RL12)
        end else if (ctrl_wr) begin
            req_q <= module_control_reg[`REQ_FIELD_MSB:`REQ_FIELD_LSB]; // (RL1)
        end
    end

    // ----------------------------------------
    // mode switch gate
    // ----------------------------------------
    always_comb begin
        switch_ok = !tx_pending; // (RL2)
        case (state_of(req_q))
            st_config: switch_ok = !tx_pending && !frame_active; // (RL7)
            st_disable: switch_ok = !tx_pending && (!frame_active || idle_seen); // (RL10)
            default: switch_ok = !tx_pending;
        endcase
    end

    always_comb begin
        state_d = state_q;
        if (wake_ev) begin
            state_d = prev_q; // (RL12)
        end else if (state_of(req_q) != state_q && switch_ok) begin
            state_d = state_of(req_q); // (RL2)
        end
    end

    // ----------------------------------------
    // mode state
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q <= st_config;
        end else begin
            state_q <= state_d;
        end
    end

    // mode held before disable, for automatic return
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prev_q <= st_normal;
        end else if (state_d == st_disable && state_q != st_disable) begin
            prev_q <= state_q; // (RL12)
        end
    end

    // ----------------------------------------
    // status toward software
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mode_request_field <= `MODE_CONFIG;
            reported_mode_field <= `MODE_CONFIG;
            config_ack_bit <= 1'b1;
        end else begin
            mode_request_field <= req_q;
            reported_mode_field <= code_of(state_q); // (RL1)
            config_ack_bit <= (state_q == st_config); // (RL4)
        end
    end

    // ----------------------------------------
    // configuration lock and functional mode
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prot_wr_grant <= 1'b0;
        end else begin
            prot_wr_grant <= prot_wr && (state_q == st_config); // (RL6)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fmode_q <= `FMODE_LEGACY; // (RL21)
        end else if (fmode_wr && state_q == st_config && fmode_wdata != `FMODE_RESERVED) begin
            fmode_q <= fmode_wdata; // (RL6)
        end
    end

    // ----------------------------------------
    // wake flag: set wins over clear
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wake_flag <= 1'b0;
        end else if (wake_ev) begin
            wake_flag <= 1'b1; // (RL11)
        end else if (wake_flag_clr) begin
            wake_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wake_irq <= 1'b0;
            wake_drop_msg <= 1'b0;
        end else begin
            wake_irq <= (wake_flag || wake_ev) && wake_irq_enable && !wake_flag_clr; // (RL11)
            wake_drop_msg <= wake_ev; // (RL12)
        end
    end

    // ----------------------------------------
    // engine steering from the entered mode
    // ----------------------------------------
    // loopback keeps the engine sending into its own receive path; the pin
    // logic below keeps those bits off the bus
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_allow <= 1'b0;
        end else begin
            tx_allow <= (state_d == st_normal) || (state_d == st_loopback); // (RL15)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_allow <= 1'b0;
        end else begin
            rx_allow <= (state_d != st_config) && (state_d != st_disable); // (RL8)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ack_err_drive <= 1'b0;
        end else begin
            ack_err_drive <= (state_d == st_normal); // (RL16)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            err_cnt_clear <= 1'b1;
        end else begin
            err_cnt_clear <= (state_d == st_config) || (state_d == st_listen); // (RL8)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            err_cnt_hold <= 1'b0;
        end else begin
            err_cnt_hold <= (state_d == st_disable); // (RL9)
        end
    end

    // clock stops once disabled; a frame in flight keeps it running
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            module_clk_en <= 1'b1;
        end else begin
            module_clk_en <= (state_d != st_disable) || frame_active; // (RL10)
        end
    end

    // ----------------------------------------
    // pins and receive path; loopback feeds the engine its own bits
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_pins_release <= 1'b0;
        end else begin
            bus_pins_release <= (state_d == st_disable); // (RL14)
        end
    end

    // normal and listen drive the pin, listen holding it recessive; configuration
    // keeps it released as it is straight after reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_tx_pin_oe <= 1'b0;
        end else begin
            bus_tx_pin_oe <= (state_d == st_normal) || (state_d == st_listen); // (RL19)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_tx_pin_out <= `RECESSIVE;
        end else begin
            bus_tx_pin_out <= (state_d == st_normal) ? engine_tx_bit : `RECESSIVE; // (RL15)
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            engine_rx_bit <= `RECESSIVE;
        end else begin
            engine_rx_bit <= (state_d == st_loopback) ? engine_tx_bit : rx_level; // (RL18)
        end
    end

    // ----------------------------------------
    // legacy resources, error recognition, acceptance routing
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            err_recog_a <= 1'b0;
            err_recog_b <= 1'b0;
            tx_buf_count <= `TX_BUF_COUNT;
            rx_buf_count <= `RX_BUF_COUNT;
        end else begin
            err_recog_a <= (fmode_q == `FMODE_LEGACY) && (rx_mode_field_a == `RXM_ERR_RECOG); // (RL20)
            err_recog_b <= (fmode_q == `FMODE_LEGACY) && (rx_mode_field_b == `RXM_ERR_RECOG); // (RL20)
            tx_buf_count <= `TX_BUF_COUNT; // (RL22)
            rx_buf_count <= `RX_BUF_COUNT; // (RL22)
        end
    end

    // first two filters serve buffer a, the other four buffer b; a zero
    // mask lets every identifier through
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            accept_a <= 1'b0;
            accept_b <= 1'b0;
        end else begin
            accept_a <= rx_frame_done && rx_allow &&
                (mask_zero_a || |filter_hit[`FILTERS_FOR_A-1:0]); // (RL17)
            accept_b <= rx_frame_done && rx_allow &&
                (mask_zero_b || |filter_hit[`FILTER_COUNT-1:`FILTERS_FOR_A]); // (RL22)
        end
    end

endmodule

// >>> verif/bus_node_model.sv
// other nodes on the bus: bit timing and short dominant frames
// assumes the bench ands node_level into the bus line
`timescale 1ns/1ps

module bus_node_model #(parameter int BIT_CLKS = 4) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // frame request from the bench
    input wire logic start_frame,
    // bus side
    output logic node_level,
    output logic bit_tick,
    output logic frame_busy
);
    logic [3:0] div_q;
    logic [3:0] left_q;
    assign bit_tick = (div_q == 4'(BIT_CLKS - 1));
    // a frame is three dominant bits; enough for an edge, short enough to keep the run small
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_q <= 4'h0;
            left_q <= 4'h0;
        end else begin
            div_q <= bit_tick ? 4'h0 : div_q + 4'h1;
            if (start_frame) left_q <= 4'h3;
            else if (bit_tick && left_q != 4'h0) left_q <= left_q - 4'h1;
        end
    end
    assign node_level = (left_q == 4'h0);
    assign frame_busy = !node_level;
endmodule

// >>> verif/can_mode_ctrl_chk.sv
// checker for the mode controller, sees only its ports
// assumes codes 0 normal, 1 disable, 2 loopback, 3 listen, 4 configuration
`timescale 1ns/1ps

module can_mode_ctrl_chk (
    // clock, reset and requests
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ctrl_wr,
    input wire logic [7:0] module_control_reg,
    input wire logic prot_wr,
    input wire logic tx_pending,
    // pins and steering
    input wire logic bus_tx_pin_out,
    input wire logic bus_tx_pin_oe,
    input wire logic bus_pins_release,
    input wire logic tx_allow,
    input wire logic rx_allow,
    input wire logic ack_err_drive,
    input wire logic err_cnt_clear,
    // status
    input wire can_mode_pkg::mode_code_type mode_request_field,
    input wire can_mode_pkg::mode_code_type reported_mode_field,
    input wire logic config_ack_bit,
    input wire can_mode_pkg::fmode_type fmode_q,
    input wire logic wake_flag,
    input wire logic wake_drop_msg,
    input wire logic prot_wr_grant
);
    import can_mode_pkg::*;
    // ----------------------------------------
    // reported mode trails the steering outputs by one cycle, hence the past values
    // ----------------------------------------
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_RESET_STATE: assert property ($rose(rst_b) |-> fmode_q == 2'h0 && config_ack_bit)
        else $error("reset state wrong");
    AST_REQ_FIELD: assert property (ctrl_wr ##1 !ctrl_wr |=>
        mode_request_field == $past(module_control_reg[7:5], 2)) else $error("request field wrong");
    AST_CFG_ACK: assert property (config_ack_bit == (reported_mode_field == 3'h4))
        else $error("config ack wrong");
    AST_CFG_QUIET: assert property (reported_mode_field == 3'h4 |->
        !$past(tx_allow) && !$past(rx_allow) && $past(err_cnt_clear)) else $error("config not quiet");
    AST_TX_NORMAL: assert property ($past(tx_allow) && $past(bus_tx_pin_oe) |-> reported_mode_field == 3'h0)
        else $error("transmit outside normal");
    AST_LISTEN: assert property (reported_mode_field == 3'h3 |->
        !$past(ack_err_drive) && !$past(tx_allow) && $past(bus_tx_pin_out)) else $error("listen drives bus");
    AST_LOOP_PIN: assert property (reported_mode_field == 3'h2 |->
        !$past(bus_tx_pin_oe) && !$past(ack_err_drive)) else $error("loopback drives pin");
    AST_DISABLE_PINS: assert property (reported_mode_field == 3'h1 |->
        $past(bus_pins_release) && !$past(bus_tx_pin_oe) && !$past(rx_allow)) else $error("disable holds pins");
    AST_HOLD_PENDING: assert property (tx_pending |=> $stable(tx_allow) && $stable(bus_tx_pin_oe))
        else $error("mode moved while pending");
    AST_PROT_LOCK: assert property (prot_wr && (tx_allow || rx_allow) |=> !prot_wr_grant)
        else $error("protected write granted online");
    AST_WAKE_DROP: assert property ($rose(wake_flag) |-> wake_drop_msg)
        else $error("wake without drop");
endmodule

// >>> verif/can_mode_ctrl_tb.sv
// self-checking bench for the mode controller: mode table, then awkward cases
// assumes the checker and the bus node model are compiled before it
`timescale 1ns/1ps

module can_mode_ctrl_tb;
    import can_mode_pkg::*;
    // ----------------------------------------
    // signals, instances and helpers
    // ----------------------------------------
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic ctrl_wr = 1'h0;
    logic [7:0] module_control_reg = 8'h80;
    logic prot_wr = 1'h0, fmode_wr = 1'h0, wake_disable = 1'h1, wake_irq_enable = 1'h0, wake_flag_clr = 1'h0;
    logic mask_zero_a = 1'h0, rx_frame_done = 1'h0, tx_pending = 1'h0, hold_active = 1'h0, start_frame = 1'h0;
    logic [1:0] rx_mode_field_b = 2'h0;
    fmode_type fmode_wdata = 2'h0;
    logic node_level, bit_tick, frame_busy, bus_tx_pin_out, bus_tx_pin_oe, bus_pins_release, config_ack_bit;
    logic wake_flag, wake_irq, prot_wr_grant, module_clk_en, tx_allow, rx_allow, ack_err_drive, err_cnt_clear;
    logic wake_drop_msg, err_recog_b, accept_a, acc, rec, err_cnt_hold;
    logic [1:0] tx_buf_count, rx_buf_count;
    mode_code_type mode_request_field, reported_mode_field;
    fmode_type fmode_q;
    int miscompares = 0;
    int samples_checked = 0;
    wire logic frame_active = frame_busy | hold_active;
    // dominant wins on the bus; a released pin reads recessive
    wire logic bus_rx_pin = node_level & (bus_tx_pin_oe ? bus_tx_pin_out : 1'h1);
    typedef struct packed {logic [2:0] code; logic [2:0] rep; logic tx, oe, rel, grant;} row_type;
    row_type rows [6] = '{'{3'h0, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0}, '{3'h3, 3'h3, 1'h0, 1'h1, 1'h0, 1'h0},
        '{3'h2, 3'h2, 1'h1, 1'h0, 1'h0, 1'h0}, '{3'h6, 3'h4, 1'h0, 1'h0, 1'h0, 1'h1},
        '{3'h1, 3'h1, 1'h0, 1'h0, 1'h1, 1'h0}, '{3'h4, 3'h4, 1'h0, 1'h0, 1'h0, 1'h1}};

    can_mode_ctrl can_mode_ctrl_inst (.core_clk, .rst_b, .ctrl_wr, .module_control_reg, .prot_wr, .fmode_wr,
        .fmode_wdata, .wake_disable, .wake_irq_enable, .wake_flag_clr, .rx_mode_field_a(2'h0), .rx_mode_field_b,
        .filter_hit(6'h00), .mask_zero_a, .mask_zero_b(1'h0), .rx_frame_done, .tx_pending, .frame_active,
        .bit_tick, .engine_tx_bit(1'h1), .bus_rx_pin, .bus_tx_pin_out, .bus_tx_pin_oe, .bus_pins_release,
        .mode_request_field, .reported_mode_field, .config_ack_bit, .fmode_q, .wake_flag, .wake_irq,
        .prot_wr_grant, .module_clk_en, .tx_allow, .rx_allow, .ack_err_drive, .err_cnt_clear, .err_cnt_hold,
        .engine_rx_bit(), .wake_drop_msg, .err_recog_a(), .err_recog_b, .accept_a, .accept_b(), .tx_buf_count,
        .rx_buf_count);
    bus_node_model bus_node_model_inst (.core_clk, .rst_b, .start_frame, .node_level, .bit_tick, .frame_busy);

    always #20 core_clk = ~core_clk;

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic request(input logic [2:0] code);
        ctrl_wr = 1'h1;
        module_control_reg = {code, 5'h00};
        tick(1);
        ctrl_wr = 1'h0;
        tick(1);
    endtask
    // bounded wait; running out ends the run
    task automatic wait_mode(input logic [2:0] code);
        for (int i = 0; i < 400 && reported_mode_field !== code; i++) tick(1);
        if (reported_mode_field !== code) begin
            check("mode wait", reported_mode_field, code);
            print_verdict();
        end
    endtask
    task automatic frame();
        start_frame = 1'h1;
        tick(1);
        start_frame = 1'h0;
    endtask
    task automatic rx_probe();
        acc = 1'h0;
        rec = 1'h0;
        rx_frame_done = 1'h1;
        tick(1);
        rx_frame_done = 1'h0;
        repeat (3) begin
            acc |= accept_a;
            rec |= err_recog_b;
            tick(1);
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        tick(16);
        rst_b = 1'h1;
        tick(1);
        check("reset mode", {config_ack_bit, reported_mode_field}, 4'hc);
        check("counts", {tx_buf_count, rx_buf_count}, 4'he);
        foreach (rows[k]) begin
            request(rows[k].code);
            wait_mode(rows[k].rep);
            check("request", mode_request_field, rows[k].code);
            check("tx_allow", tx_allow, rows[k].tx);
            check("pin_oe", bus_tx_pin_oe, rows[k].oe);
            check("release", bus_pins_release, rows[k].rel);
            check("clk_en", module_clk_en, !rows[k].rel);
            check("cnt_hold", err_cnt_hold, rows[k].rel);
            prot_wr = 1'h1;
            tick(1);
            prot_wr = 1'h0;
            check("grant", prot_wr_grant, rows[k].grant);
        end
        // the later request replaces the waiting one
        tx_pending = 1'h1;
        request(3'h3);
        request(3'h0);
        tick(10);
        check("pending", reported_mode_field, 3'h4);
        tx_pending = 1'h0;
        wait_mode(3'h0);
        request(3'h3);
        wait_mode(3'h3);
        rx_probe();
        check("reject", {acc, rec}, 2'h0);
        mask_zero_a = 1'h1;
        rx_mode_field_b = 2'h3;
        rx_probe();
        check("accept", acc, 1'h1);
        check("err recog", rec, 1'h1);
        request(3'h0);
        wait_mode(3'h0);
        frame();
        request(3'h4);
        tick(4);
        check("busy defer", reported_mode_field, 3'h0);
        wait_mode(3'h4);
        check("idle entry", frame_busy, 1'h0);
        request(3'h0);
        wait_mode(3'h0);
        hold_active = 1'h1;
        frame();
        request(3'h1);
        tick(40);
        check("idle bits", reported_mode_field, 3'h0);
        wait_mode(3'h1);
        hold_active = 1'h0;
        frame();
        tick(20);
        check("wake off", {reported_mode_field, wake_flag}, 4'h2);
        wake_disable = 1'h0;
        wake_irq_enable = 1'h1;
        frame();
        wait_mode(3'h0);
        check("wake", {wake_flag, wake_irq, mode_request_field}, 5'h18);
        wake_flag_clr = 1'h1;
        tick(1);
        wake_flag_clr = 1'h0;
        tick(1);
        check("wake clear", wake_flag, 1'h0);
        request(3'h4);
        wait_mode(3'h4);
        fmode_wdata = 2'h2;
        fmode_wr = 1'h1;
        tick(1);
        fmode_wr = 1'h0;
        check("fmode set", fmode_q, 2'h2);
        rst_b = 1'h0;
        tick(2);
        rst_b = 1'h1;
        tick(1);
        check("fmode reset", fmode_q, 2'h0);
        print_verdict();
    end
endmodule

bind can_mode_ctrl can_mode_ctrl_chk can_mode_ctrl_chk_inst (.core_clk, .rst_b, .ctrl_wr, .module_control_reg,
    .prot_wr, .tx_pending, .bus_tx_pin_out, .bus_tx_pin_oe, .bus_pins_release, .tx_allow, .rx_allow,
    .ack_err_drive, .err_cnt_clear, .mode_request_field, .reported_mode_field, .config_ack_bit, .fmode_q,
    .wake_flag, .wake_drop_msg, .prot_wr_grant);
